// [hw/tcu_regs.vh]
// Register map, field positions and divider counts of the timer/counter unit
`ifndef TCU_REGS_VH
`define TCU_REGS_VH

`define TCU_RST_BYTE 8'h00
`define TCU_BYTE_MAX 8'hff
`define TCU_WORD_MAX 16'hffff

`define TCU_A_CTL01 8'h88
`define TCU_A_MODE01 8'h89
`define TCU_A_TL0 8'h8a
`define TCU_A_TL1 8'h8b
`define TCU_A_TH0 8'h8c
`define TCU_A_TH1 8'h8d
`define TCU_A_CLKSEL 8'h8e
`define TCU_A_T2CTL 8'hc8
`define TCU_A_T2RLL 8'hca
`define TCU_A_T2RLH 8'hcb
`define TCU_A_T2CNTL 8'hcc
`define TCU_A_T2CNTH 8'hcd
`define TCU_A_T3CTL 8'h91
`define TCU_A_T3RLL 8'h92
`define TCU_A_T3RLH 8'h93
`define TCU_A_T3CNTL 8'h94
`define TCU_A_T3CNTH 8'h95

`define TCU_B_RUN0 0
`define TCU_B_RUN1 1
`define TCU_B_RUN0H 2
`define TCU_B_OVF0 4
`define TCU_B_OVF1 5
`define TCU_B_OVF0H 6

`define TCU_F_MODE0 1:0
`define TCU_B_CNT0 2
`define TCU_F_MODE1 5:4
`define TCU_B_CNT1 6
`define TCU_M13 2'b00
`define TCU_M16 2'b01
`define TCU_M8R 2'b10
`define TCU_M8S 2'b11

`define TCU_F_PRESCALE 1:0
`define TCU_B_SYS0 2
`define TCU_B_SYS1 3
`define TCU_B_SYS2 4
`define TCU_B_SYS3 5
`define TCU_PS_DIV12 2'b00
`define TCU_PS_DIV4 2'b01
`define TCU_PS_DIV48 2'b10
`define TCU_PS_EXT8 2'b11

`define TCU_B_XCLK 0
`define TCU_B_CAP 1
`define TCU_B_RUN 2
`define TCU_B_SPLIT 3
`define TCU_B_ALT 5
`define TCU_F_CTLW 5:0
`define TCU_B_OVFL 6
`define TCU_B_OVFH 7

`define TCU_DIV12_LAST 4'hb
`define TCU_DIV48_LAST 6'h2f
`define TCU_DIV4_LAST 2'h3
`define TCU_DIV8_LAST 3'h7

`endif

// [hw/tcu_reload_timer.v]
// Auto-reload timer: 16-bit or split 8-bit, with capture into reload
`timescale 1ns/1ps
`default_nettype none
`include "tcu_regs.vh"

module tcu_reload_timer (
    input wire clk,
    input wire rst,
    input wire run,
    input wire split,
    input wire cap_en,
    input wire tick,
    input wire cap_evt,
    input wire [7:0] wdata,
    input wire wr_cnt_lo,
    input wire wr_cnt_hi,
    input wire wr_rld_lo,
    input wire wr_rld_hi,
    input wire wr_flags,
    output reg [15:0] cnt_r,
    output reg [15:0] rld_r,
    output reg ovf_hi_r,
    output reg ovf_lo_r
);
    reg [15:0] cnt_nxt;
    reg [15:0] rld_nxt;
    reg set_hi;
    reg set_lo;
    reg ovf_hi_nxt;
    reg ovf_lo_nxt;

    always @* begin
        cnt_nxt = cnt_r;
        rld_nxt = rld_r;
        set_hi = 1'b0;
        set_lo = 1'b0;
        if (run && tick) begin
            if (split) begin
                if (cnt_r[7:0] == `TCU_BYTE_MAX) begin
                    cnt_nxt[7:0] = rld_r[7:0];
                    set_lo = 1'b1;
                end else begin
                    cnt_nxt[7:0] = cnt_r[7:0] + 8'h01;
                end
                if (cnt_r[15:8] == `TCU_BYTE_MAX) begin
                    cnt_nxt[15:8] = rld_r[15:8];
                    set_hi = 1'b1;
                end else begin
                    cnt_nxt[15:8] = cnt_r[15:8] + 8'h01;
                end
            end else if (cnt_r == `TCU_WORD_MAX) begin
                cnt_nxt = rld_r;
                set_hi = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end
        if (wr_cnt_lo) begin
            cnt_nxt[7:0] = wdata;
        end
        if (wr_cnt_hi) begin
            cnt_nxt[15:8] = wdata;
        end
        if (wr_rld_lo) begin
            rld_nxt[7:0] = wdata;
        end
        if (wr_rld_hi) begin
            rld_nxt[15:8] = wdata;
        end
        // A capture beats a software write of the same reload byte
        if (cap_en && cap_evt) begin
            rld_nxt = cnt_r;
            set_hi = 1'b1;
        end
        // Hardware set wins over a software clear in the same cycle
        ovf_hi_nxt = (wr_flags ? wdata[`TCU_B_OVFH] : ovf_hi_r) | set_hi;
        ovf_lo_nxt = (wr_flags ? wdata[`TCU_B_OVFL] : ovf_lo_r) | set_lo;
    end

    always @(posedge clk) begin
        if (rst) begin
            cnt_r <= {`TCU_RST_BYTE, `TCU_RST_BYTE};
            rld_r <= {`TCU_RST_BYTE, `TCU_RST_BYTE};
            ovf_hi_r <= 1'b0;
            ovf_lo_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            rld_r <= rld_nxt;
            ovf_hi_r <= ovf_hi_nxt;
            ovf_lo_r <= ovf_lo_nxt;
        end
    end
endmodule // tcu_reload_timer

`default_nettype wire

// [hw/tcu_timer_unit.v]
// Four-timer counter/timer unit with its special function registers
`timescale 1ns/1ps
`default_nettype none
`include "tcu_regs.vh"

module tcu_timer_unit (
    input wire MCLK,
    input wire SYS_RST,
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    input wire SFR_WR,
    input wire SFR_RD,
    output reg [7:0] SFR_RDATA,
    input wire TIMER0_COUNT_INPUT,
    input wire TIMER1_COUNT_INPUT,
    input wire RTC_OSC,
    input wire EXT_OSC,
    input wire CMP0_OUT,
    input wire CMP1_OUT,
    output wire [6:0] OVF_FLAGS
);
    // Asynchronous inputs: pin0, pin1, rtc, ext, cmp0, cmp1
    reg [5:0] sync1_r;
    reg [5:0] sync2_r;
    reg [5:0] sync3_r;
    wire pin0_fall;
    wire pin1_fall;
    wire rtc_rise;
    wire ext_rise;
    wire cmp0_rise;
    wire cmp1_rise;

    reg [3:0] div12_r;
    reg [5:0] div48_r;
    reg [2:0] rtc8_r;
    reg [2:0] ext8_r;
    wire tick12;
    wire tick4;
    wire tick48;
    wire rtc_tick8;
    wire ext_tick8;
    reg pre_tick;

    reg [7:0] ctl_r;
    reg [7:0] mode_r;
    reg [7:0] clksel_r;
    reg [5:0] t2ctl_r;
    reg [5:0] t3ctl_r;
    reg [7:0] tl0_r;
    reg [7:0] th0_r;
    reg [7:0] tl1_r;
    reg [7:0] th1_r;
    reg ovf0_r;
    reg ovf1_r;
    reg ovf0h_r;
    reg [7:0] tl0_nxt;
    reg [7:0] th0_nxt;
    reg [7:0] tl1_nxt;
    reg [7:0] th1_nxt;
    reg set0;
    reg set1;
    reg set0h;
    reg [16:0] step0;
    reg [16:0] step1;
    reg [7:0] rdata_nxt;

    wire wr_ctl;
    wire t0_tmr_tick;
    wire t1_tmr_tick;
    wire t0_tick;
    wire t1_tick;
    wire t2_tick;
    wire t3_tick;
    wire t2_cap;
    wire t3_cap;
    wire [15:0] t2_cnt;
    wire [15:0] t2_rld;
    wire [15:0] t3_cnt;
    wire [15:0] t3_rld;
    wire t2_ovfh;
    wire t2_ovfl;
    wire t3_ovfh;
    wire t3_ovfl;

    // Step of a classic timer: {overflow, high byte, low byte}
    function [16:0] t01_step;
        input [1:0] md;
        input [7:0] th;
        input [7:0] tl;
        reg [13:0] v13;
        begin
            v13 = {1'b0, th, tl[4:0]} + 14'h0001;
            case (md)
                `TCU_M13: t01_step = {v13[13], v13[12:5], tl[7:5], v13[4:0]};
                `TCU_M16: t01_step = {1'b0, th, tl} + 17'h00001;
                `TCU_M8R: begin
                    if (tl == `TCU_BYTE_MAX) begin
                        t01_step = {1'b1, th, th};
                    end else begin
                        t01_step = {1'b0, th, tl + 8'h01};
                    end
                end
                default: t01_step = {tl == `TCU_BYTE_MAX, th, tl + 8'h01};
            endcase
        end
    endfunction

    // Two stages before use, third stage only for edge detection
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            sync1_r <= 6'h3f;
            sync2_r <= 6'h3f;
            sync3_r <= 6'h3f;
        end else begin
            sync1_r <= {CMP1_OUT, CMP0_OUT, EXT_OSC, RTC_OSC,
                        TIMER1_COUNT_INPUT, TIMER0_COUNT_INPUT};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Pin is seen at sysclk rate, so two-cycle levels are always caught
    assign pin0_fall = sync3_r[0] & ~sync2_r[0];
    assign pin1_fall = sync3_r[1] & ~sync2_r[1];
    assign rtc_rise = ~sync3_r[2] & sync2_r[2];
    assign ext_rise = ~sync3_r[3] & sync2_r[3];
    assign cmp0_rise = ~sync3_r[4] & sync2_r[4];
    assign cmp1_rise = ~sync3_r[5] & sync2_r[5];

    // Divided clocks are one-cycle enables, not derived clocks
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            div12_r <= 4'h0;
            div48_r <= 6'h00;
            rtc8_r <= 3'h0;
            ext8_r <= 3'h0;
        end else begin
            div12_r <= tick12 ? 4'h0 : div12_r + 4'h1;
            div48_r <= tick48 ? 6'h00 : div48_r + 6'h01;
            if (rtc_rise) begin
                rtc8_r <= rtc8_r + 3'h1;
            end
            if (ext_rise) begin
                ext8_r <= ext8_r + 3'h1;
            end
        end
    end

    assign tick12 = (div12_r == `TCU_DIV12_LAST);
    assign tick48 = (div48_r == `TCU_DIV48_LAST);
    assign tick4 = (div48_r[1:0] == `TCU_DIV4_LAST);
    assign rtc_tick8 = rtc_rise && (rtc8_r == `TCU_DIV8_LAST);
    assign ext_tick8 = ext_rise && (ext8_r == `TCU_DIV8_LAST);

    always @* begin
        case (clksel_r[`TCU_F_PRESCALE])
            `TCU_PS_DIV12: pre_tick = tick12;
            `TCU_PS_DIV4: pre_tick = tick4;
            `TCU_PS_DIV48: pre_tick = tick48;
            default: pre_tick = ext_tick8;
        endcase
    end

    assign t0_tmr_tick = clksel_r[`TCU_B_SYS0] | pre_tick;
    assign t1_tmr_tick = clksel_r[`TCU_B_SYS1] | pre_tick;
    assign t0_tick = mode_r[`TCU_B_CNT0] ? pin0_fall : t0_tmr_tick;
    assign t1_tick = mode_r[`TCU_B_CNT1] ? pin1_fall : t1_tmr_tick;

    // In capture mode the alternate source paces captures, not counting
    assign t2_tick = clksel_r[`TCU_B_SYS2] ? 1'b1 :
        (t2ctl_r[`TCU_B_XCLK] && !t2ctl_r[`TCU_B_CAP]) ?
        (t2ctl_r[`TCU_B_ALT] ? cmp0_rise : rtc_tick8) : tick12;
    assign t3_tick = clksel_r[`TCU_B_SYS3] ? 1'b1 :
        (t3ctl_r[`TCU_B_XCLK] && !t3ctl_r[`TCU_B_CAP]) ?
        (t3ctl_r[`TCU_B_ALT] ? cmp1_rise : ext_tick8) : tick12;
    assign t2_cap = t2ctl_r[`TCU_B_ALT] ? cmp0_rise : rtc_rise;
    assign t3_cap = t3ctl_r[`TCU_B_ALT] ? cmp1_rise : ext_tick8;

    assign wr_ctl = SFR_WR && (SFR_ADDR == `TCU_A_CTL01);

    always @* begin
        step0 = t01_step(mode_r[`TCU_F_MODE0], th0_r, tl0_r);
        step1 = t01_step(mode_r[`TCU_F_MODE1], th1_r, tl1_r);
        tl0_nxt = tl0_r;
        th0_nxt = th0_r;
        tl1_nxt = tl1_r;
        th1_nxt = th1_r;
        set0 = 1'b0;
        set1 = 1'b0;
        set0h = 1'b0;
        if (ctl_r[`TCU_B_RUN0] && t0_tick) begin
            tl0_nxt = step0[7:0];
            if (mode_r[`TCU_F_MODE0] != `TCU_M8S) begin
                th0_nxt = step0[15:8];
            end
            set0 = step0[16];
        end
        // Split mode: high byte of Timer 0 is a second 8-bit timer
        if (mode_r[`TCU_F_MODE0] == `TCU_M8S && ctl_r[`TCU_B_RUN0H] &&
            t0_tmr_tick) begin
            th0_nxt = th0_r + 8'h01;
            set0h = (th0_r == `TCU_BYTE_MAX);
        end
        // Timer 1 has no split mode; selecting it holds the count
        if (ctl_r[`TCU_B_RUN1] && t1_tick &&
            mode_r[`TCU_F_MODE1] != `TCU_M8S) begin
            tl1_nxt = step1[7:0];
            th1_nxt = step1[15:8];
            set1 = step1[16];
        end
        if (SFR_WR && SFR_ADDR == `TCU_A_TL0) begin
            tl0_nxt = SFR_WDATA;
        end
        if (SFR_WR && SFR_ADDR == `TCU_A_TH0) begin
            th0_nxt = SFR_WDATA;
        end
        if (SFR_WR && SFR_ADDR == `TCU_A_TL1) begin
            tl1_nxt = SFR_WDATA;
        end
        if (SFR_WR && SFR_ADDR == `TCU_A_TH1) begin
            th1_nxt = SFR_WDATA;
        end
    end

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            ctl_r <= `TCU_RST_BYTE;
            mode_r <= `TCU_RST_BYTE;
            clksel_r <= `TCU_RST_BYTE;
            t2ctl_r <= 6'h00;
            t3ctl_r <= 6'h00;
            tl0_r <= `TCU_RST_BYTE;
            th0_r <= `TCU_RST_BYTE;
            tl1_r <= `TCU_RST_BYTE;
            th1_r <= `TCU_RST_BYTE;
            ovf0_r <= 1'b0;
            ovf1_r <= 1'b0;
            ovf0h_r <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl_r <= SFR_WDATA;
            end
            if (SFR_WR && SFR_ADDR == `TCU_A_MODE01) begin
                mode_r <= SFR_WDATA;
            end
            if (SFR_WR && SFR_ADDR == `TCU_A_CLKSEL) begin
                clksel_r <= SFR_WDATA;
            end
            if (SFR_WR && SFR_ADDR == `TCU_A_T2CTL) begin
                t2ctl_r <= SFR_WDATA[`TCU_F_CTLW];
            end
            if (SFR_WR && SFR_ADDR == `TCU_A_T3CTL) begin
                t3ctl_r <= SFR_WDATA[`TCU_F_CTLW];
            end
            tl0_r <= tl0_nxt;
            th0_r <= th0_nxt;
            tl1_r <= tl1_nxt;
            th1_r <= th1_nxt;
            // Set wins over a software clear landing in the same cycle
            ovf0_r <= (wr_ctl ? SFR_WDATA[`TCU_B_OVF0] : ovf0_r) | set0;
            ovf1_r <= (wr_ctl ? SFR_WDATA[`TCU_B_OVF1] : ovf1_r) | set1;
            ovf0h_r <= (wr_ctl ? SFR_WDATA[`TCU_B_OVF0H] : ovf0h_r) | set0h;
        end
    end

    tcu_reload_timer u_t2 (
        .clk(MCLK),
        .rst(SYS_RST),
        .run(t2ctl_r[`TCU_B_RUN]),
        .split(t2ctl_r[`TCU_B_SPLIT]),
        .cap_en(t2ctl_r[`TCU_B_CAP]),
        .tick(t2_tick),
        .cap_evt(t2_cap),
        .wdata(SFR_WDATA),
        .wr_cnt_lo(SFR_WR && SFR_ADDR == `TCU_A_T2CNTL),
        .wr_cnt_hi(SFR_WR && SFR_ADDR == `TCU_A_T2CNTH),
        .wr_rld_lo(SFR_WR && SFR_ADDR == `TCU_A_T2RLL),
        .wr_rld_hi(SFR_WR && SFR_ADDR == `TCU_A_T2RLH),
        .wr_flags(SFR_WR && SFR_ADDR == `TCU_A_T2CTL),
        .cnt_r(t2_cnt),
        .rld_r(t2_rld),
        .ovf_hi_r(t2_ovfh),
        .ovf_lo_r(t2_ovfl)
    );

    tcu_reload_timer u_t3 (
        .clk(MCLK),
        .rst(SYS_RST),
        .run(t3ctl_r[`TCU_B_RUN]),
        .split(t3ctl_r[`TCU_B_SPLIT]),
        .cap_en(t3ctl_r[`TCU_B_CAP]),
        .tick(t3_tick),
        .cap_evt(t3_cap),
        .wdata(SFR_WDATA),
        .wr_cnt_lo(SFR_WR && SFR_ADDR == `TCU_A_T3CNTL),
        .wr_cnt_hi(SFR_WR && SFR_ADDR == `TCU_A_T3CNTH),
        .wr_rld_lo(SFR_WR && SFR_ADDR == `TCU_A_T3RLL),
        .wr_rld_hi(SFR_WR && SFR_ADDR == `TCU_A_T3RLH),
        .wr_flags(SFR_WR && SFR_ADDR == `TCU_A_T3CTL),
        .cnt_r(t3_cnt),
        .rld_r(t3_rld),
        .ovf_hi_r(t3_ovfh),
        .ovf_lo_r(t3_ovfl)
    );

    // Flag bits of the control registers read back the live flags
    always @* begin
        if (SFR_ADDR == `TCU_A_CTL01) begin
            rdata_nxt = {1'b0, ovf0h_r, ovf1_r, ovf0_r, ctl_r[3:0]};
        end else if (SFR_ADDR == `TCU_A_MODE01) begin
            rdata_nxt = mode_r;
        end else if (SFR_ADDR == `TCU_A_CLKSEL) begin
            rdata_nxt = clksel_r;
        end else if (SFR_ADDR == `TCU_A_TL0) begin
            rdata_nxt = tl0_r;
        end else if (SFR_ADDR == `TCU_A_TH0) begin
            rdata_nxt = th0_r;
        end else if (SFR_ADDR == `TCU_A_TL1) begin
            rdata_nxt = tl1_r;
        end else if (SFR_ADDR == `TCU_A_TH1) begin
            rdata_nxt = th1_r;
        end else if (SFR_ADDR == `TCU_A_T2CTL) begin
            rdata_nxt = {t2_ovfh, t2_ovfl, t2ctl_r};
        end else if (SFR_ADDR == `TCU_A_T2RLL) begin
            rdata_nxt = t2_rld[7:0];
        end else if (SFR_ADDR == `TCU_A_T2RLH) begin
            rdata_nxt = t2_rld[15:8];
        end else if (SFR_ADDR == `TCU_A_T2CNTL) begin
            rdata_nxt = t2_cnt[7:0];
        end else if (SFR_ADDR == `TCU_A_T2CNTH) begin
            rdata_nxt = t2_cnt[15:8];
        end else if (SFR_ADDR == `TCU_A_T3CTL) begin
            rdata_nxt = {t3_ovfh, t3_ovfl, t3ctl_r};
        end else if (SFR_ADDR == `TCU_A_T3RLL) begin
            rdata_nxt = t3_rld[7:0];
        end else if (SFR_ADDR == `TCU_A_T3RLH) begin
            rdata_nxt = t3_rld[15:8];
        end else if (SFR_ADDR == `TCU_A_T3CNTL) begin
            rdata_nxt = t3_cnt[7:0];
        end else if (SFR_ADDR == `TCU_A_T3CNTH) begin
            rdata_nxt = t3_cnt[15:8];
        end else begin
            rdata_nxt = `TCU_RST_BYTE;
        end
    end

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            SFR_RDATA <= `TCU_RST_BYTE;
        end else if (SFR_RD) begin
            SFR_RDATA <= rdata_nxt;
        end
    end

    assign OVF_FLAGS = {ovf0h_r, t3_ovfh, t3_ovfl, t2_ovfh, t2_ovfl,
                        ovf1_r, ovf0_r};
endmodule // tcu_timer_unit

`default_nettype wire

// [tb/tcu_checker.sv]
// Port-level assertions for the timer/counter unit
`timescale 1ns/1ps
`default_nettype none
module tcu_checker (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic TIMER0_COUNT_INPUT,
    input wire logic TIMER1_COUNT_INPUT,
    input wire logic RTC_OSC,
    input wire logic EXT_OSC,
    input wire logic CMP0_OUT,
    input wire logic CMP1_OUT,
    input wire logic [6:0] OVF_FLAGS
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // Reload bytes have no hardware writer unless capture is on
    property p_readback(logic [7:0] a);
        (SFR_WR && SFR_ADDR == a) ##2 (SFR_RD && !SFR_WR && SFR_ADDR == a)
            |=> SFR_RDATA == $past(SFR_WDATA, 3);
    endproperty
    a_reset_clears: assert property (disable iff (1'b0)
        SYS_RST |=> SFR_RDATA == 8'h00 && OVF_FLAGS == 7'h00)
        else $error("state not cleared by reset");
    a_rdata_holds: assert property (
        !SFR_RD |=> $stable(SFR_RDATA))
        else $error("read data moved without a read");
    a_flags_sticky: assert property (
        !SFR_WR |=> (OVF_FLAGS & $past(OVF_FLAGS)) == $past(OVF_FLAGS))
        else $error("flag dropped without a write");
    a_unmapped_zero: assert property (
        SFR_RD && SFR_ADDR == 8'h00 |=> SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_rld2_low: assert property (p_readback(8'hca))
        else $error("reload low readback wrong");
    a_rld2_high: assert property (p_readback(8'hcb))
        else $error("reload high readback wrong");
    a_rld3_low: assert property (p_readback(8'h92))
        else $error("timer3 reload low readback wrong");
    a_rld3_high: assert property (p_readback(8'h93))
        else $error("timer3 reload high readback wrong");
    c_capture: cover property ($rose(OVF_FLAGS[3]));
    c_split3: cover property ($rose(OVF_FLAGS[4]));
    c_t0_high: cover property ($rose(OVF_FLAGS[6]));
endmodule // tcu_checker
bind tcu_timer_unit tcu_checker chk_i (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_RDATA(SFR_RDATA), .TIMER0_COUNT_INPUT(TIMER0_COUNT_INPUT),
    .TIMER1_COUNT_INPUT(TIMER1_COUNT_INPUT), .RTC_OSC(RTC_OSC),
    .EXT_OSC(EXT_OSC), .CMP0_OUT(CMP0_OUT), .CMP1_OUT(CMP1_OUT),
    .OVF_FLAGS(OVF_FLAGS)
);
`default_nettype wire

// [tb/tcu_pins_model.sv]
// Far side: count pins, oscillators and comparator outputs
`timescale 1ns/1ps
`default_nettype none
module tcu_pins_model (
    input wire logic clk,
    output wire logic t0_pin,
    output wire logic t1_pin,
    output wire logic rtc_osc,
    output wire logic ext_osc,
    output wire logic cmp0,
    output wire logic cmp1
);
    // Pins idle high, clocks and comparators idle low
    logic [5:0] lv = 6'h03;
    assign {cmp1, cmp0, ext_osc, rtc_osc, t1_pin, t0_pin} = lv;
    // Line idx goes away from idle and back n times, each level hold cycles
    task automatic pulse(input int idx, input int n, input int hold);
        repeat (n) begin
            repeat (2) begin
                @(negedge clk);
                lv[idx] = ~lv[idx];
                repeat (hold - 1) @(negedge clk);
            end
        end
    endtask
endmodule // tcu_pins_model
`default_nettype wire

// [tb/tcu_timer_unit_bench.sv]
// Self-checking bench for the timer/counter unit
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_unit_bench;
    logic mclk;
    logic sys_rst;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic sfr_wr;
    logic sfr_rd;
    wire [7:0] sfr_rdata;
    wire [6:0] flags;
    wire p0, p1, rtc, ext, c0, c1;
    int fail_count;
    int checked;

    tcu_timer_unit dut (.MCLK(mclk), .SYS_RST(sys_rst), .SFR_ADDR(sfr_addr),
        .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
        .SFR_RDATA(sfr_rdata), .TIMER0_COUNT_INPUT(p0),
        .TIMER1_COUNT_INPUT(p1), .RTC_OSC(rtc), .EXT_OSC(ext),
        .CMP0_OUT(c0), .CMP1_OUT(c1), .OVF_FLAGS(flags));
    tcu_pins_model pins (.clk(mclk), .t0_pin(p0), .t1_pin(p1),
        .rtc_osc(rtc), .ext_osc(ext), .cmp0(c0), .cmp1(c1));

    always #5 mclk = ~mclk;

    task automatic complete_run;
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chkr(input int lo, input int hi, input logic [7:0] g);
        checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t expected %h..%h got %h", $time, lo, hi, g);
        end
    endtask
    // One write every two cycles, so the strobe never toggles twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge mclk);
        sfr_rd = 1'b0;
        v = sfr_rdata;
    endtask

    task automatic t_reset_vals;
        logic [7:0] v;
        logic [7:0] a [5] = '{8'hca, 8'hcb, 8'hcc, 8'h88, 8'h00};
        chk(16'h0, {9'h0, flags});
        foreach (a[i]) begin
            rd(a[i], v);
            chk(16'h0, {8'h0, v});
        end
    endtask
    task automatic t_reload_rw;
        logic [7:0] v;
        logic [7:0] a [5] = '{8'hca, 8'hcb, 8'h92, 8'h93, 8'h00};
        logic [7:0] d [5] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'hff};
        foreach (a[i]) begin
            wr(a[i], d[i]);
            rd(a[i], v);
            chk({8'h0, (a[i] == 8'h00) ? 8'h00 : d[i]}, {8'h0, v});
        end
    endtask
    task automatic t_count_pins;
        logic [7:0] v;
        wr(8'h89, 8'h55);
        wr(8'h8a, 8'h00);
        wr(8'h8b, 8'h00);
        wr(8'h88, 8'h03);
        fork
            pins.pulse(0, 5, 2);
            pins.pulse(1, 3, 3);
        join
        repeat (6) @(negedge mclk);
        rd(8'h8a, v);
        chk(16'd5, {8'h0, v});
        rd(8'h8b, v);
        chk(16'd3, {8'h0, v});
        wr(8'h88, 8'h00);
    endtask
    task automatic t_prescale;
        logic [7:0] v;
        int e;
        for (int i = 0; i < 3; i++) begin
            e = (i == 0) ? 40 : (i == 1) ? 120 : 10;
            wr(8'h8e, 8'(i));
            wr(8'h89, 8'h01);
            wr(8'h8a, 8'h00);
            wr(8'h88, 8'h01);
            repeat (480) @(negedge mclk);
            wr(8'h88, 8'h00);
            rd(8'h8a, v);
            chkr(e - 1, e + 1, v);
        end
    endtask
    task automatic t_t0_modes;
        logic [7:0] v;
        wr(8'h8e, 8'h04);
        wr(8'h89, 8'h02);
        wr(8'h8c, 8'hfe);
        wr(8'h8a, 8'hfe);
        wr(8'h88, 8'h01);
        repeat (5) @(negedge mclk);
        chk(16'h1, {15'h0, flags[0]});
        wr(8'h88, 8'h00);
        rd(8'h8a, v);
        chkr(8'hfe, 8'hff, v);
        wr(8'h89, 8'h03);
        wr(8'h88, 8'h04);
        repeat (5) @(negedge mclk);
        chk(16'h2, {14'h0, flags[6], flags[0]});
        wr(8'h88, 8'h00);
    endtask
    task automatic t_t23_reload;
        logic [7:0] v;
        wr(8'h8e, 8'h30);
        wr(8'hca, 8'hf0);
        wr(8'hcb, 8'hff);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'h92, 8'h80);
        wr(8'h94, 8'hfe);
        wr(8'h95, 8'hfe);
        wr(8'hc8, 8'h04);
        wr(8'h91, 8'h0c);
        repeat (6) @(negedge mclk);
        chk(16'he, {12'h0, flags[5:2]});
        wr(8'hc8, 8'h00);
        wr(8'h91, 8'h00);
        rd(8'hcc, v);
        chkr(8'hf0, 8'hff, v);
    endtask
    task automatic t_t2_div12;
        logic [7:0] v;
        wr(8'h8e, 8'h00);
        wr(8'hcc, 8'h00);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h04);
        repeat (238) @(negedge mclk);
        wr(8'hc8, 8'h00);
        rd(8'hcc, v);
        chkr(19, 21, v);
    endtask
    task automatic t_alt_clocks;
        logic [7:0] v;
        wr(8'hcc, 8'h00);
        wr(8'h94, 8'h00);
        wr(8'hc8, 8'h25);
        wr(8'h91, 8'h05);
        fork
            pins.pulse(4, 4, 3);
            pins.pulse(3, 16, 2);
        join
        repeat (6) @(negedge mclk);
        rd(8'hcc, v);
        chk(16'd4, {8'h0, v});
        rd(8'h94, v);
        chk(16'd2, {8'h0, v});
        wr(8'hc8, 8'h00);
        wr(8'h91, 8'h00);
    endtask
    task automatic t_capture;
        logic [7:0] v;
        wr(8'h8e, 8'h10);
        wr(8'hcc, 8'h00);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h06);
        repeat (20) @(negedge mclk);
        pins.pulse(2, 1, 20);
        chk(16'h1, {15'h0, flags[3]});
        rd(8'hca, v);
        chkr(15, 45, v);
        wr(8'hc8, 8'h00);
        chk(16'h0, {9'h0, flags});
    endtask
    // Two sysclk ticks carry 13-bit Timer 1 over; the stop write loses
    task automatic t_t1_13bit;
        logic [7:0] v;
        wr(8'h8e, 8'h08);
        wr(8'h89, 8'h00);
        wr(8'h8b, 8'hfe);
        wr(8'h8d, 8'hff);
        wr(8'h88, 8'h02);
        wr(8'h88, 8'h00);
        chk(16'h2, {14'h0, flags[1:0]});
        rd(8'h8b, v);
        chk(16'he0, {8'h0, v});
        rd(8'h8d, v);
        chk(16'h0, {8'h0, v});
        wr(8'h88, 8'h00);
    endtask
    // Ext/8 prescale, slow oscillator/8 and comparator 1 capture
    task automatic t_alt_sources;
        logic [7:0] v;
        wr(8'h8e, 8'h23);
        wr(8'h89, 8'h01);
        wr(8'h8a, 8'h00);
        wr(8'hcc, 8'h00);
        wr(8'h94, 8'h00);
        wr(8'h95, 8'h00);
        wr(8'hc8, 8'h05);
        wr(8'h91, 8'h26);
        wr(8'h88, 8'h01);
        fork
            pins.pulse(3, 16, 2);
            pins.pulse(2, 8, 2);
            pins.pulse(5, 1, 2);
        join
        repeat (6) @(negedge mclk);
        rd(8'h8a, v);
        chk(16'd2, {8'h0, v});
        rd(8'hcc, v);
        chk(16'd1, {8'h0, v});
        rd(8'h92, v);
        chkr(3, 8, v);
        chk(16'h1, {15'h0, flags[5]});
        wr(8'h88, 8'h00);
        wr(8'hc8, 8'h00);
        wr(8'h91, 8'h00);
    endtask

    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        fail_count = 0;
        checked = 0;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset_vals();
        t_reload_rw();
        t_count_pins();
        t_prescale();
        t_t0_modes();
        t_t23_reload();
        t_t2_div12();
        t_alt_clocks();
        t_capture();
        t_t1_13bit();
        t_alt_sources();
        complete_run();
    end
    // Tests take about 2150 cycles; a hang is cut well after that
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        complete_run();
    end
endmodule // tcu_timer_unit_bench
`default_nettype wire
